/* File: design/pcx_core.sv */
// Purpose: Executes control and data-move opcodes of one picoproc thread
// Assumes: One instruction per cycle on instr_valid; GPR file is outside
// Notes:   ALU flags and GPR contents arrive as inputs, PC is kept here
//
// Strobed register access and the register offsets were chosen for this implementation.

`timescale 1ns/100ps
`default_nettype none

module pcx_core
    import pcx_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              instr_valid,
    input  wire pcx_instr_t        instr,
    input  wire logic [3:0]        alu_flags,
    input  wire logic [511:0]      gpr_file,
    input  wire logic [5:0]        qw_addr,
    output pcx_region_t            qw_region,
    output logic [PC_W-1:0]        pc,
    output logic                   thread_busy,
    output pcx_xfer_t              xfer,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    output logic                   irq
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [PC_W-1:0]              pc;
        logic                          busy;
        logic [SP_W:0]                 sp;       // Entries in use
        logic [STACK_DEPTH-1:0][15:0]  stack;
        logic [EV_W-1:0]               status;
        logic [EV_W-1:0]               mask;
        pcx_xfer_t                     xfer;
        logic [31:0]                   rdata;
    } pcx_state_t;
    pcx_state_t st_reg;                  // Registered state
    pcx_state_t st_next;                 // Next state

    // ==========================================================
    // Condition evaluation, flags are Z C N V from bit 3 down
    function automatic logic cond_ok(input logic [3:0] c,
                                     input logic [3:0] f);
        logic z, cy, n, v;
        z  = f[3];
        cy = f[2];
        n  = f[1];
        v  = f[0];
        unique case (c)
            COND_ZS:  cond_ok = z;
            COND_ZC:  cond_ok = !z;
            COND_CS:  cond_ok = cy;
            COND_HI:  cond_ok = cy && !z;
            COND_LS:  cond_ok = !cy || z;
            COND_CC:  cond_ok = !cy;
            COND_RSV: cond_ok = 1'b0;
            COND_AL:  cond_ok = 1'b1;
            COND_NC:  cond_ok = !n;
            COND_NS:  cond_ok = n;
            COND_GE:  cond_ok = (n == v);
            COND_GT:  cond_ok = !z && (n == v);
            COND_LE:  cond_ok = z || (n != v);
            COND_LT:  cond_ok = (n != v);
            COND_VS:  cond_ok = v;
            COND_VC:  cond_ok = !v;
        endcase
    endfunction

    // GPR word by index
    function automatic logic [31:0] gpr_word(input logic [511:0] g,
                                             input logic [3:0] i);
        gpr_word = g[i*32 +: 32];
    endfunction

    // GPR halfword by halfword index, even index is the high half
    function automatic logic [15:0] gpr_half(input logic [511:0] g,
                                             input logic [3:0] w,
                                             input logic h);
        logic [31:0] word;
        word = gpr_word(g, w);
        gpr_half = h ? word[15:0] : word[31:16];
    endfunction

    // ==========================================================
    // Quadword region lookup
    always_comb begin
        if (qw_addr == QW_STACK1) begin
            qw_region = PCX_RG_STACK1;
        end else if (qw_addr >= QW_SCR0_LO && qw_addr <= QW_SCR0_HI) begin
            qw_region = PCX_RG_SCR0;
        end else if (qw_addr >= QW_POOL_LO && qw_addr <= QW_POOL_HI) begin
            qw_region = PCX_RG_POOL;
        end else if (qw_addr >= QW_SCR1_LO && qw_addr <= QW_SCR1_HI) begin
            qw_region = PCX_RG_SCR1;
        end else if (qw_addr >= QW_TREE_LO) begin
            qw_region = PCX_RG_TREE;
        end else begin
            qw_region = PCX_RG_OTHER;
        end
    end

    // ==========================================================
    // Next-state logic
    logic             go;                // Instruction executes
    logic [15:0]      base;              // Branch base
    logic [15:0]      ai_addr;           // Address-indirect sum
    logic [EV_W-1:0]  ev;                // Events this cycle
    always_comb begin
        st_next = st_reg;
        ev      = '0;
        base    = '0;
        ai_addr = '0;
        st_next.xfer.valid = 1'b0;
        go = instr_valid && cond_ok(instr.cond, alu_flags);
        if (instr_valid) begin
            // Normal advance; every op takes one cycle
            st_next.pc = st_reg.pc + 16'h0001;
            st_next.busy = 1'b1;
            unique case (instr.op)
                PCX_OP_NOP: begin
                end
                PCX_OP_EXIT: begin
                    if (go) begin
                        st_next.busy = 1'b0;
                        ev[EV_EXIT] = 1'b1;
                    end
                end
                PCX_OP_TBR: begin
                    // Unconditional form, flags never touched here
                    if (gpr_file[{instr.target_register_field,
                            instr.bit_position_field}] == instr.test_bit) begin
                        st_next.pc = st_reg.pc
                                   + instr.relative_displacement;
                    end
                end
                PCX_OP_BAL: begin
                    if (go) begin
                        if (st_reg.sp == (SP_W+1)'(STACK_DEPTH)) begin
                            ev[EV_STK_OVF] = 1'b1;
                        end else begin
                            st_next.stack[st_reg.sp[SP_W-1:0]] =
                                st_reg.pc + 16'h0001;
                            st_next.sp = st_reg.sp + 1'b1;
                        end
                        if (instr.target_register_field != 4'h0) begin
                            base = gpr_half(gpr_file,
                                            instr.target_register_field,
                                            instr.half_sel);
                        end
                        st_next.pc = base + instr.target_offset_field;
                    end
                end
                PCX_OP_RET: begin
                    if (go) begin
                        if (st_reg.sp == '0) begin
                            ev[EV_STK_UND] = 1'b1;
                        end else begin
                            st_next.pc = st_reg.stack[
                                SP_W'(st_reg.sp - 1'b1)];
                            st_next.sp = st_reg.sp - 1'b1;
                        end
                    end
                end
                PCX_OP_BREG: begin
                    if (go) begin
                        st_next.pc = gpr_half(gpr_file,
                                              instr.target_register_field,
                                              instr.half_sel);
                    end
                end
                PCX_OP_BREL: begin
                    if (go) begin
                        st_next.pc = st_reg.pc
                                   + instr.relative_displacement;
                    end
                end
                PCX_OP_BRO: begin
                    if (go) begin
                        if (instr.target_register_field != 4'h0) begin
                            base = gpr_half(gpr_file,
                                            instr.target_register_field,
                                            1'b0);
                        end
                        st_next.pc = base + instr.target_offset_field;
                    end
                end
                PCX_OP_MIND: begin
                    if (go) begin
                        st_next.xfer.valid = 1'b1;
                        st_next.xfer.is_array = 1'b1;
                        st_next.xfer.cop_num = instr.cop_num;
                        st_next.xfer.array_select = instr.array_select;
                        st_next.xfer.offset = 8'(gpr_half(gpr_file,
                            {2'b00, instr.base_register_field[2:1]},
                            instr.base_register_field[0])
                            + 16'(instr.short_immediate_offset));
                        st_next.xfer.header_skip = instr.header_skip;
                    end
                end
                PCX_OP_MAIND: begin
                    if (go) begin
                        ai_addr = gpr_half(gpr_file,
                            {2'b00, instr.base_register_field[2:1]},
                            instr.base_register_field[0])
                            + 16'(instr.byte_immediate_offset);
                        st_next.xfer.valid = 1'b1;
                        st_next.xfer.is_array = ai_addr[AI_ARRAY_BIT];
                        st_next.xfer.cop_num =
                            ai_addr[AI_COP_HI:AI_COP_LO];
                        st_next.xfer.array_select =
                            ai_addr[AI_ARR_HI:AI_ARR_LO];
                        st_next.xfer.offset = ai_addr[7:0];
                        st_next.xfer.header_skip = instr.header_skip;
                    end
                end
                default: begin
                end
            endcase
            // Common transfer fields
            if (instr.op == PCX_OP_MIND || instr.op == PCX_OP_MAIND) begin
                st_next.xfer.transfer_type_field =
                    instr.transfer_type_field;
                // Top bit clear means load, set means store
                st_next.xfer.is_load = !instr.transfer_type_field[4];
                st_next.xfer.data_register = instr.data_register;
                st_next.xfer.store_data =
                    gpr_word(gpr_file, instr.data_register);
            end
        end
        // Register port; set beats a write-one-to-clear
        st_next.rdata = '0;
        if (reg_wr && reg_addr == REG_STATUS) begin
            st_next.status = st_reg.status & ~reg_wdata[EV_W-1:0];
        end
        if (reg_wr && reg_addr == REG_MASK) begin
            st_next.mask = reg_wdata[EV_W-1:0];
        end
        st_next.status = st_next.status | ev;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: st_next.rdata = 32'(st_reg.status);
                REG_MASK:   st_next.rdata = 32'(st_reg.mask);
                REG_PC:     st_next.rdata = 32'(st_reg.pc);
                REG_SP:     st_next.rdata = 32'(st_reg.sp);
                default:    st_next.rdata = '0;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_reg        <= '0;
            st_reg.pc     <= PC_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pc          = st_reg.pc;
    assign thread_busy = st_reg.busy;
    assign xfer        = st_reg.xfer;
    assign reg_rdata   = st_reg.rdata;
    assign irq         = |(st_reg.status & st_reg.mask);

    // ==========================================================
    // Checks
    sequence s_bal_full;
        instr_valid && instr.op == PCX_OP_BAL
            && cond_ok(instr.cond, alu_flags)
            && st_reg.sp == (SP_W+1)'(STACK_DEPTH);
    endsequence
    property p_reserved_noop;
        @(posedge sys_clk) disable iff (srst)
        instr_valid && instr.cond == COND_RSV
            && instr.op != PCX_OP_TBR && instr.op != PCX_OP_NOP
        |=> pc == $past(pc) + 16'h0001 && !xfer.valid;
    endproperty
    a_reserved_noop: assert property (p_reserved_noop)
        else $error("reserved condition changed flow");
    property p_nop;
        @(posedge sys_clk) disable iff (srst)
        instr_valid && instr.op == PCX_OP_NOP
        |=> pc == $past(pc) + 16'h0001 && $stable(st_reg.sp);
    endproperty
    a_nop: assert property (p_nop)
        else $error("nop altered state");
    property p_exit;
        @(posedge sys_clk) disable iff (srst)
        instr_valid && instr.op == PCX_OP_EXIT && instr.cond == COND_AL
        |=> !thread_busy;
    endproperty
    a_exit: assert property (p_exit)
        else $error("exit left thread busy");
    property p_bal_ovf;
        @(posedge sys_clk) disable iff (srst)
        s_bal_full |=> st_reg.status[EV_STK_OVF] && $stable(st_reg.sp);
    endproperty
    a_bal_ovf: assert property (p_bal_ovf)
        else $error("full stack not flagged");
    property p_ret_empty;
        @(posedge sys_clk) disable iff (srst)
        instr_valid && instr.op == PCX_OP_RET && instr.cond == COND_AL
            && st_reg.sp == '0
        |=> st_reg.status[EV_STK_UND];
    endproperty
    a_ret_empty: assert property (p_ret_empty)
        else $error("empty return not flagged");
    property p_brel;
        @(posedge sys_clk) disable iff (srst)
        instr_valid && instr.op == PCX_OP_BREL && instr.cond == COND_AL
        |=> pc == $past(pc) + $past(instr.relative_displacement);
    endproperty
    a_brel: assert property (p_brel)
        else $error("relative branch target wrong");
    property p_bro_zero;
        @(posedge sys_clk) disable iff (srst)
        instr_valid && instr.op == PCX_OP_BRO && instr.cond == COND_AL
            && instr.target_register_field == 4'h0
        |=> pc == $past(instr.target_offset_field);
    endproperty
    a_bro_zero: assert property (p_bro_zero)
        else $error("zero-base branch target wrong");
    property p_always;
        @(posedge sys_clk) disable iff (srst)
        instr_valid && instr.op == PCX_OP_MAIND && instr.cond == COND_AL
        |=> xfer.valid ##1 !xfer.valid || $past(instr_valid);
    endproperty
    a_always: assert property (p_always)
        else $error("always condition did not execute");
    property p_dir;
        @(posedge sys_clk) disable iff (srst)
        xfer.valid |-> xfer.is_load == !xfer.transfer_type_field[4];
    endproperty
    a_dir: assert property (p_dir)
        else $error("transfer direction mismatch");
endmodule

`default_nettype wire

/* File: inc/pcx_pkg.sv */
// Purpose: Shared constants and carriers for the control and move decoder
// Assumes: 16-bit program counter, 16 x 32-bit GPRs per thread
// Notes:   Encodings of opcode classes are local choices of this block

`default_nettype none

package pcx_pkg;

    // ==========================================================
    // Sizes
    localparam int PC_W        = 16;
    localparam int STACK_DEPTH = 16;
    localparam int SP_W        = 4;

    // ==========================================================
    // Condition selector codes
    localparam logic [3:0] COND_ZS   = 4'h0;
    localparam logic [3:0] COND_ZC   = 4'h1;
    localparam logic [3:0] COND_CS   = 4'h2;
    localparam logic [3:0] COND_HI   = 4'h3;
    localparam logic [3:0] COND_LS   = 4'h4;
    localparam logic [3:0] COND_CC   = 4'h5;
    localparam logic [3:0] COND_RSV  = 4'h6;
    localparam logic [3:0] COND_AL   = 4'h7;
    localparam logic [3:0] COND_NC   = 4'h8;
    localparam logic [3:0] COND_NS   = 4'h9;
    localparam logic [3:0] COND_GE   = 4'ha;
    localparam logic [3:0] COND_GT   = 4'hb;
    localparam logic [3:0] COND_LE   = 4'hc;
    localparam logic [3:0] COND_LT   = 4'hd;
    localparam logic [3:0] COND_VS   = 4'he;
    localparam logic [3:0] COND_VC   = 4'hf;

    // ==========================================================
    // Address-indirect field positions
    localparam int AI_ARRAY_BIT = 14;
    localparam int AI_COP_HI    = 13;
    localparam int AI_COP_LO    = 10;
    localparam int AI_ARR_HI    = 9;
    localparam int AI_ARR_LO    = 8;

    // ==========================================================
    // Shared memory quadword map
    localparam logic [5:0] QW_STACK1    = 6'h0b;
    localparam logic [5:0] QW_SCR0_LO   = 6'h0c;
    localparam logic [5:0] QW_SCR0_HI   = 6'h0f;
    localparam logic [5:0] QW_POOL_LO   = 6'h10;
    localparam logic [5:0] QW_POOL_HI   = 6'h17;
    localparam logic [5:0] QW_SCR1_LO   = 6'h18;
    localparam logic [5:0] QW_SCR1_HI   = 6'h1f;
    localparam logic [5:0] QW_TREE_LO   = 6'h20;

    // Region codes
    typedef enum logic [2:0] {
        PCX_RG_OTHER,
        PCX_RG_STACK1,
        PCX_RG_SCR0,
        PCX_RG_POOL,
        PCX_RG_SCR1,
        PCX_RG_TREE
    } pcx_region_t;

    // Instruction kinds handled here
    typedef enum logic [3:0] {
        PCX_OP_NOP,
        PCX_OP_EXIT,
        PCX_OP_TBR,
        PCX_OP_BAL,
        PCX_OP_RET,
        PCX_OP_BREG,
        PCX_OP_BREL,
        PCX_OP_BRO,
        PCX_OP_MIND,
        PCX_OP_MAIND
    } pcx_op_t;

    // ==========================================================
    // Decoded instruction carrier
    typedef struct packed {
        pcx_op_t      op;
        logic [3:0]   cond;
        logic [3:0]   target_register_field;
        logic         half_sel;
        logic [4:0]   bit_position_field;
        logic         test_bit;
        logic [15:0]  relative_displacement;
        logic [15:0]  target_offset_field;
        logic [4:0]   transfer_type_field;
        logic [3:0]   data_register;
        logic [3:0]   cop_num;
        logic [1:0]   array_select;
        logic [2:0]   base_register_field;
        logic [5:0]   short_immediate_offset;
        logic [7:0]   byte_immediate_offset;
        logic         header_skip;
    } pcx_instr_t;

    // Data interface request carrier
    typedef struct packed {
        logic         valid;
        logic         is_array;
        logic         is_load;
        logic [4:0]   transfer_type_field;
        logic [3:0]   cop_num;
        logic [1:0]   array_select;
        logic [7:0]   offset;
        logic         header_skip;
        logic [3:0]   data_register;
        logic [31:0]  store_data;
    } pcx_xfer_t;

    // Status event bits
    localparam int EV_W        = 3;
    localparam int EV_STK_OVF  = 0;
    localparam int EV_STK_UND  = 1;
    localparam int EV_EXIT     = 2;

    // Register offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK   = 4'h1;
    localparam logic [3:0] REG_PC     = 4'h2;
    localparam logic [3:0] REG_SP     = 4'h3;

    // Reset values
    localparam logic [15:0] PC_RESET = 16'h0000;

endpackage

`default_nettype wire

/* File: bench/pcx_cop_model.sv */
// Purpose: Far-side coprocessor store that takes transfer requests
// Assumes: Requests are one-cycle pulses on xfer.valid
// Notes:   Counts requests so the bench can see pulse width and gating
`timescale 1ns/100ps
`default_nettype none
module pcx_cop_model
    import pcx_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire pcx_xfer_t xfer,
    output logic [7:0]     req_count
);
    // ==========================================================
    // Array store
    logic [31:0] mem [0:255]; // Only stores land here
    initial req_count = 8'h00;
    // A held valid would count twice, which the bench would see
    always @(posedge sys_clk) begin
        if (xfer.valid === 1'b1) begin
            req_count <= req_count + 8'h01;
            if (!xfer.is_load) begin
                mem[xfer.offset] <= xfer.store_data;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the control and move decoder
// Assumes: One instruction per run call; answers one cycle later
// Notes:   Expected pc is tracked here, never read back from the design
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import pcx_pkg::*;
    // ==========================================================
    // Signals
    logic sys_clk = 0, srst = 1, instr_valid = 0, reg_wr = 0, reg_rd = 0;
    logic irq, busy;
    logic [3:0] flags = 0, reg_addr = 0;
    logic [5:0] qw = 0;
    logic [7:0] cnt;
    logic [15:0] pc, ep;
    logic [31:0] d, reg_wdata = 0, reg_rdata, miscompares = 0, tests_run = 0;
    logic [511:0] gpr = 0;
    pcx_instr_t ins, instr = '0;
    pcx_xfer_t xfer;
    pcx_region_t rg;
    logic [15:0] stk [$];
    int i;
    always #5 sys_clk = ~sys_clk;
    pcx_core pcx_core_i (.sys_clk(sys_clk), .srst(srst),
        .instr_valid(instr_valid), .instr(instr), .alu_flags(flags),
        .gpr_file(gpr), .qw_addr(qw), .qw_region(rg), .pc(pc),
        .thread_busy(busy), .xfer(xfer), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    pcx_cop_model pcx_cop_model_i (.sys_clk(sys_clk), .xfer(xfer),
        .req_count(cnt));
    // ==========================================================
    // Helpers
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic run(logic [3:0] f);
        @(posedge sys_clk) begin instr <= ins; flags <= f; end
        instr_valid <= 1;
        @(posedge sys_clk) instr_valid <= 0;
        #1;
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] v);
        @(posedge sys_clk) begin reg_addr <= a; reg_wdata <= v; end
        reg_wr <= 1;
        @(posedge sys_clk) reg_wr <= 0;
        #1;
    endtask
    task automatic rd(logic [3:0] a);
        @(posedge sys_clk) reg_addr <= a;
        reg_rd <= 1;
        @(posedge sys_clk) reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    // Flags are {Z,C,N,V}
    function automatic logic ok(logic [3:0] c, logic [3:0] f);
        logic z, cy, n, v;
        {z, cy, n, v} = f;
        case (c)
            4'h0: return z;       4'h1: return !z;
            4'h2: return cy;      4'h3: return cy && !z;
            4'h4: return !cy || z; 4'h5: return !cy;
            4'h6: return 1'b0;    4'h7: return 1'b1;
            4'h8: return !n;      4'h9: return n;
            4'ha: return n == v;  4'hb: return !z && n == v;
            4'hc: return z || n != v; 4'hd: return n != v;
            4'he: return v;       default: return !v;
        endcase
    endfunction
    function automatic pcx_region_t rgf(logic [5:0] q);
        if (q == 6'h0b) return PCX_RG_STACK1;
        if (q >= 6'h0c && q <= 6'h0f) return PCX_RG_SCR0;
        if (q >= 6'h10 && q <= 6'h17) return PCX_RG_POOL;
        if (q >= 6'h18 && q <= 6'h1f) return PCX_RG_SCR1;
        if (q >= 6'h20) return PCX_RG_TREE;
        return PCX_RG_OTHER;
    endfunction
    // Watchdog so a hang still reaches the verdict
    initial begin
        #500000;
        miscompares++;
        results();
    end
    // ==========================================================
    // Main sequence
    initial begin
        ins = '0;
        gpr[32+:32] = 32'h4a12_0130; // Word 1: array address in high half
        gpr[64+:32] = 32'h0000_0020; // Word 2: bit 5 set
        repeat (12) @(posedge sys_clk);
        srst <= 0;
        #1 chk("pc", 32'(pc), 0);
        chk("busy", 32'(busy), 0);
        rd(REG_STATUS); chk("status", d, 0);
        rd(REG_MASK); chk("mask", d, 0);
        rd(4'h9); chk("unmapped", d, 0);
        ep = 0;
        ins.op = PCX_OP_BREL; // Every code against every flag pattern
        ins.relative_displacement = 16'h0010;
        for (i = 0; i < 256; i++) begin
            ins.cond = 4'(i >> 4);
            ep = ep + (ok(ins.cond, 4'(i)) ? 16'h0010 : 16'h0001);
            run(4'(i)); chk("cond", 32'(pc), 32'(ep));
        end
        ins.op = PCX_OP_NOP;
        ep++; run(4'h0); chk("nop", 32'(pc), 32'(ep));
        ins.op = PCX_OP_BAL; ins.cond = COND_AL; // Fill stack past its end
        for (i = 0; i < 17; i++) begin
            ins.target_offset_field = 16'h0100 + 16'(i);
            if (i < 16) stk.push_back(ep + 16'h0001);
            ep = ins.target_offset_field;
            run(4'h0); chk("bal", 32'(pc), 32'(ep));
        end
        rd(REG_SP); chk("depth", d, 16);
        rd(REG_STATUS); chk("ovf", d, 1);
        wr(REG_MASK, 7); chk("irq", 32'(irq), 1);
        ins.op = PCX_OP_RET;
        for (i = 0; i < 17; i++) begin
            if (i < 16) ep = stk.pop_back();
            run(4'h0);
            if (i < 16) chk("ret", 32'(pc), 32'(ep));
        end
        rd(REG_STATUS); chk("und", d, 3);
        wr(REG_STATUS, 3); chk("irq_clr", 32'(irq), 0);
        ins.op = PCX_OP_BREG; ins.target_register_field = 4'h1;
        run(4'h0); chk("breg_hi", 32'(pc), 32'h4a12);
        ins.half_sel = 1;
        run(4'h0); chk("breg_lo", 32'(pc), 32'h0130);
        ins.op = PCX_OP_BAL; ins.target_offset_field = 16'h0002;
        run(4'h0); chk("bal_lo", 32'(pc), 32'h0132);
        ins.op = PCX_OP_BRO; ins.half_sel = 0;
        run(4'h0); chk("bro", 32'(pc), 32'h4a14);
        ins.target_register_field = 0; ins.target_offset_field = 16'h0200;
        run(4'h0); chk("bro0", 32'(pc), 32'h0200);
        ins.op = PCX_OP_TBR; ins.cond = COND_RSV; ins.test_bit = 1;
        ins.target_register_field = 4'h2; ins.bit_position_field = 5;
        ins.relative_displacement = 16'h0008;
        run(4'h0); chk("tbr", 32'(pc), 32'h0208);
        ins.test_bit = 0;
        run(4'h0); chk("tbr_no", 32'(pc), 32'h0209);
        ins.op = PCX_OP_EXIT; ins.cond = COND_ZS;
        run(4'h0); chk("exit_no", 32'(busy), 1);
        run(4'h8); chk("exit", 32'(busy), 0);
        chk("irq_exit", 32'(irq), 1);
        ins.op = PCX_OP_MIND; ins.cond = COND_AL; ins.data_register = 2;
        ins.base_register_field = 3; ins.short_immediate_offset = 5;
        ins.cop_num = 3; ins.array_select = 1; ins.header_skip = 1;
        ins.transfer_type_field = 5'h10;
        run(4'h0); chk("mi", 32'({xfer.valid, xfer.is_array, xfer.is_load,
            xfer.cop_num, xfer.array_select, xfer.offset}),
            32'h18d35);
        chk("mi_d", xfer.store_data, 32'h20);
        chk("mi_t", 32'(xfer.transfer_type_field), 32'h10);
        chk("mi_x", 32'({xfer.header_skip, xfer.data_register}),
            32'h12);
        ins.op = PCX_OP_MAIND; ins.base_register_field = 2;
        ins.byte_immediate_offset = 8'h03; ins.transfer_type_field = 5'h01;
        run(4'h0); chk("mai", 32'({xfer.valid, xfer.is_array, xfer.is_load,
            xfer.cop_num, xfer.array_select, xfer.offset}),
            32'h1ca15);
        ins.cond = COND_RSV;
        run(4'h0); @(posedge sys_clk) #1 chk("cnt", 32'(cnt), 2);
        for (i = 0; i < 64; i++) begin
            @(posedge sys_clk) qw <= 6'(i);
            #1 chk("qw", 32'(rg), 32'(rgf(6'(i))));
        end
        // Mid-run reset must drop stack, status and busy left from above
        @(posedge sys_clk) srst <= 1;
        @(posedge sys_clk) srst <= 0;
        #1 chk("rst_pc", 32'(pc), 0);
        chk("rst_busy", 32'(busy), 0);
        chk("rst_irq", 32'(irq), 0);
        rd(REG_SP); chk("rst_sp", d, 0);
        results();
    end
endmodule
`default_nettype wire
